// ==== dv/bank_chk_assertions.sv ====
// Checker for the control and mask register bank
`timescale 1ns/1ps
module bank_chk #(
  parameter int RESET_CYCLES = 4
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [5:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  // Control outputs
  input wire logic        frame_check_select,
  input wire logic [5:0]  frame_bits,
  input wire logic        shared_threshold_select,
  input wire logic [3:0]  average_flush,
  input wire logic        field_supply_on,
  input wire logic        power_on_flag_clear,
  input wire logic        core_reset,
  input wire logic        hard_reset_out,
  input wire logic        irq
);
  import adc_ctrl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [15:0] wd_q;
  int unsigned run_q;
  logic        rw;
  logic        cw;
  // Writes inside a reset pulse are dropped, so leave them out
  assign rw = reg_wr && reg_addr == CONTROL_ADDR && !core_reset;
  assign cw = rw && reg_wdata[1:0] == 2'h0;
  always_ff @(posedge clk) begin
    wd_q  <= reg_wdata;
    run_q <= core_reset ? run_q + 1 : 0;
  end
  frame_len_a: assert property (frame_bits == (frame_check_select ? FRAME_LONG : FRAME_SHORT))
    else $error("frame length wrong");
  shared_sel_a: assert property (cw |=> shared_threshold_select == wd_q[14])
    else $error("shared select wrong");
  flush_pulse_a: assert property (cw ##1 !reg_wr |-> average_flush == wd_q[7:4] ##1 average_flush == 4'h0)
    else $error("flush pulse wrong");
  supply_off_a: assert property (cw |=> field_supply_on == !wd_q[3])
    else $error("supply state wrong");
  por_pulse_a: assert property (cw && reg_wdata[2] ##1 !reg_wr |-> power_on_flag_clear ##1 !power_on_flag_clear)
    else $error("power-on clear pulse wrong");
  reset_start_a: assert property (rw && reg_wdata[1:0] != 2'h0 |=> core_reset && hard_reset_out == wd_q[0])
    else $error("reset pulse did not start");
  reset_len_a: assert property ($fell(core_reset) |-> run_q == RESET_CYCLES && !irq)
    else $error("reset pulse length wrong");
  hard_supply_a: assert property (hard_reset_out |-> core_reset && !field_supply_on)
    else $error("supply on during hard reset");
  unmapped_read_a: assert property (reg_rd && (reg_addr < STATUS_ADDR || reg_addr > CONTROL_ADDR) |=> reg_rvalid && reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  cover property (core_reset && hard_reset_out);
  cover property ($rose(irq));
  cover property (cw && reg_wdata[15]);
endmodule // bank_chk

bind adc_ctrl_bank bank_chk #(.RESET_CYCLES(RESET_CYCLES)) i_chk (.clk(clk), .srst(srst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .frame_check_select(frame_check_select), .frame_bits(frame_bits), .shared_threshold_select(shared_threshold_select),
  .average_flush(average_flush), .field_supply_on(field_supply_on), .power_on_flag_clear(power_on_flag_clear),
  .core_reset(core_reset), .hard_reset_out(hard_reset_out), .irq(irq));

// ==== dv/reg_host.sv ====
// Host model issuing single register reads and writes
`timescale 1ns/1ps
module reg_host (
  // Clock
  input  wire logic        clk,
  // Register port
  output logic             reg_wr = 1'b0,
  output logic             reg_rd = 1'b0,
  output logic [5:0]       reg_addr = 6'h3F,
  output logic [15:0]      reg_wdata = 16'h0000,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  // Whole 16-bit words; data inverted after use so stale values never match
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Answer stands for one cycle after the read edge; look once it has settled
    #1;
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule // reg_host

// ==== dv/tb.sv ====
// Self-checking bench for the control and mask register bank
`timescale 1ns/1ps
module tb;
  import adc_ctrl_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        done_p = 1'b0;
  logic [3:0]  ev = 4'h0;
  logic [3:0]  cmp = 4'h0;
  logic        reg_wr, reg_rd, reg_rvalid, irq, fsel, shr, sup, por, crst, hrst, rd_v;
  logic [3:0]  flush;
  logic [5:0]  reg_addr, fbits;
  logic [15:0] reg_wdata, reg_rdata, rd_d;
  int n_errors = 0;
  int checked = 0;
  always #5 clk = ~clk;
  adc_ctrl_bank i_dut (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .channel_done(done_p),
    .converter_fault_flag(ev[3]), .data_loss_event(ev[2]), .frame_error_flag(ev[1]), .check_error_flag(ev[0]),
    .comparator_level(cmp), .frame_check_select(fsel), .frame_bits(fbits), .shared_threshold_select(shr),
    .average_flush(flush), .field_supply_on(sup), .power_on_flag_clear(por), .core_reset(crst),
    .hard_reset_out(hrst), .irq(irq));
  reg_host i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
    i_host.rd(a, rd_d, rd_v);
    chk({15'h0, rd_v}, 16'h0001, "read valid");
    chk(rd_d, e, "read data");
  endtask
  // Source b of the mask layout; comparators pulse high for one cycle
  task automatic fire(input int b, input int n);
    @(posedge clk);
    if (b == 12) repeat (n) begin
      done_p <= 1'b1;
      @(posedge clk);
      done_p <= 1'b0;
      @(posedge clk);
    end else if (b >= 8) begin
      ev[b-8] <= 1'b1;
      @(posedge clk);
      ev[b-8] <= 1'b0;
    end else begin
      cmp[b%4] <= 1'b1;
      @(posedge clk);
      cmp[b%4] <= 1'b0;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_map();
    rdchk(MASK_ADDR, 16'h0000);
    rdchk(CONTROL_ADDR, 16'h0000);
    i_host.wr(6'h15, 16'hFFFF);
    rdchk(6'h15, 16'h0000);
    i_host.wr(MASK_ADDR, 16'hFFFF);
    rdchk(MASK_ADDR, 16'h1FFF);
  endtask
  task automatic t_ctrl();
    i_host.wr(CONTROL_ADDR, 16'hFFF0);
    #1;
    chk({12'h0, flush}, 16'h000F, "flush");
    chk({10'h0, fbits}, 16'h0020, "long frame");
    chk({13'h0, fsel, shr, sup}, 16'h0007, "selects");
    @(posedge clk);
    #1;
    chk({12'h0, flush}, 16'h0000, "flush end");
    rdchk(CONTROL_ADDR, 16'hC0F0);
    i_host.wr(CONTROL_ADDR, 16'h001C);
    #1;
    chk({9'h0, fbits, sup}, 16'h0030, "short frame, supply off");
    chk({12'h0, flush}, 16'h0001, "flush ch1 only");
    chk({15'h0, por}, 16'h0001, "por clear");
    @(posedge clk);
    #1;
    chk({15'h0, por}, 16'h0000, "por clear end");
    rdchk(CONTROL_ADDR, 16'h0018);
  endtask
  task automatic t_irq();
    logic [15:0] e;
    for (int b = 0; b < 13; b++) begin
      e = (b >= 8) ? 16'h0001 << b : 16'h0011 << (b % 4);
      i_host.wr(MASK_ADDR, MASK_WMASK & ~e);
      fire(b, 4);
      chk({15'h0, irq}, 16'h0000, "masked");
      rdchk(STATUS_ADDR, e);
      i_host.wr(MASK_ADDR, 16'h0001 << b);
      if (b == 12) fire(b, 3);
      chk({15'h0, irq}, 16'h0000, "early");
      fire(b, (b == 12) ? 1 : 4);
      chk({15'h0, irq}, 16'h0001, "enabled");
      rdchk(STATUS_ADDR, e);
      #1;
      chk({15'h0, irq}, 16'h0000, "cleared");
    end
  endtask
  // Comparator 1 held high then low, so rise and fall flags arrive apart
  task automatic t_edge();
    i_host.wr(MASK_ADDR, 16'h0001);
    @(posedge clk);
    cmp[0] <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0, irq}, 16'h0000, "rise under fall mask");
    i_host.wr(MASK_ADDR, 16'h0010);
    #1;
    chk({15'h0, irq}, 16'h0001, "rise enabled");
    rdchk(STATUS_ADDR, 16'h0010);
    i_host.wr(MASK_ADDR, 16'h0001);
    @(posedge clk);
    cmp[0] <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0, irq}, 16'h0001, "fall enabled");
    rdchk(STATUS_ADDR, 16'h0001);
  endtask
  task automatic t_rst(input logic [15:0] d);
    i_host.wr(CONTROL_ADDR, 16'hC008 | d);
    #1;
    for (int i = 0; i <= RESET_PULSE_CYC; i++) begin
      chk({14'h0, crst, hrst}, (i < RESET_PULSE_CYC) ? {14'h0, 1'b1, d[0]} : 16'h0000, "pulse");
      if (d[0] || i == RESET_PULSE_CYC) chk({15'h0, sup}, {15'h0, i == RESET_PULSE_CYC && !d[0]}, "supply");
      @(posedge clk);
      #1;
    end
    // Hard reset keeps the supply off one cycle past the pulse
    chk({15'h0, sup}, 16'h0001, "supply back on");
    rdchk(MASK_ADDR, 16'h0000);
    rdchk(CONTROL_ADDR, 16'h0000);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_map();
    t_ctrl();
    t_irq();
    t_edge();
    t_rst(16'h0002);
    t_rst(16'h0001);
    end_sim();
  end
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
endmodule // tb

// ==== logic/adc_ctrl_bank.sv ====
// Control and interrupt-mask register bank with status flags and interrupt line
`timescale 1ns/1ps
module adc_ctrl_bank
  import adc_ctrl_pkg::*;
#(
  parameter int RESET_CYCLES = adc_ctrl_pkg::RESET_PULSE_CYC
) (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               srst,
  // Register port from the serial controller
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [adc_ctrl_pkg::REG_W-1:0]     reg_wdata,
  output logic      [adc_ctrl_pkg::REG_W-1:0]     reg_rdata,
  output logic                                    reg_rvalid,
  // Event pulses from the converter, link and serial logic
  input  wire logic                               channel_done,
  input  wire logic                               converter_fault_flag,
  input  wire logic                               data_loss_event,
  input  wire logic                               frame_error_flag,
  input  wire logic                               check_error_flag,
  // Comparator outputs, levels from the same clock
  input  wire logic [adc_ctrl_pkg::CHANNELS-1:0]  comparator_level,
  // Control outputs
  output logic                                    frame_check_select,
  output logic [5:0]                              frame_bits,
  output logic                                    shared_threshold_select,
  output logic [adc_ctrl_pkg::CHANNELS-1:0]       average_flush,
  output logic                                    field_supply_on,
  output logic                                    power_on_flag_clear,
  output logic                                    core_reset,
  output logic                                    hard_reset_out,
  output logic                                    irq
);
  import adc_ctrl_pkg::*;

  initial begin
    if (RESET_CYCLES < 1) begin
      $error("adc_ctrl_bank: RESET_CYCLES must be at least 1");
    end
  end

  // Register state
  logic [REG_W-1:0]    control_reg, control_next;
  logic [REG_W-1:0]    mask_reg, mask_next;
  logic [REG_W-1:0]    status_reg, status_next;
  logic [CHANNELS-1:0] level_reg, level_next;
  logic [1:0]          chan_cnt_reg, chan_cnt_next;
  logic [REG_W-1:0]    rdata_reg, rdata_next;
  logic                rvalid_reg, rvalid_next;
  logic [CHANNELS-1:0] flush_reg, flush_next;
  logic                por_clr_reg, por_clr_next;
  logic                irq_reg, irq_next;
  logic                soft_req, hard_req;
  logic                core_pulse, hard_pulse;
  logic                bank_reset;
  logic [REG_W-1:0]    events;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
    return a == target;
  endfunction

  // Register reset also taken by the internal soft and hard resets
  assign bank_reset = srst | core_pulse;

  assign soft_req = reg_wr && hit(reg_addr, CONTROL_ADDR) && reg_wdata[SOFT_RESET_BIT];
  assign hard_req = reg_wr && hit(reg_addr, CONTROL_ADDR) && reg_wdata[HARD_RESET_BIT];

  // One stretcher for both requests, so core_reset leaves a flop directly
  pulse_stretch #(
    .WIDTH   (RESET_CYCLES)
  ) u_core (
    .clk     (clk),
    .srst    (srst),
    .trigger (soft_req || hard_req),
    .pulse   (core_pulse)
  );

  pulse_stretch #(
    .WIDTH   (RESET_CYCLES)
  ) u_hard (
    .clk     (clk),
    .srst    (srst),
    .trigger (hard_req),
    .pulse   (hard_pulse)
  );

  // Event collection into status positions
  always_comb begin
    events = '0;
    level_next = comparator_level;
    chan_cnt_next = chan_cnt_reg;
    if (channel_done) begin
      chan_cnt_next = chan_cnt_reg + 2'h1;
    end
    // Done only once channel 4 completes a 1..4 sweep
    events[DONE_BIT]      = channel_done && (chan_cnt_reg == 2'h3);
    events[FAULT_BIT]     = converter_fault_flag;
    events[LOSS_BIT]      = data_loss_event;
    events[FRAME_ERR_BIT] = frame_error_flag;
    events[CHECK_ERR_BIT] = check_error_flag;
    events[RISE_LSB +: CHANNELS] = comparator_level & ~level_reg;
    events[FALL_LSB +: CHANNELS] = ~comparator_level & level_reg;
  end

  // Register writes, sticky flags, read path
  always_comb begin
    control_next = control_reg;
    mask_next    = mask_reg;
    status_next  = status_reg;
    rdata_next   = rdata_reg;
    rvalid_next  = 1'b0;
    flush_next   = '0;
    por_clr_next = 1'b0;
    if (reg_wr && hit(reg_addr, CONTROL_ADDR)) begin
      // Reset and clear bits 2..0 never stored; flush bits kept for read-back
      control_next = reg_wdata & CONTROL_WMASK;
      flush_next   = reg_wdata[FLUSH_LSB +: CHANNELS];
      por_clr_next = reg_wdata[POR_CLEAR_BIT];
    end
    if (reg_wr && hit(reg_addr, MASK_ADDR)) begin
      mask_next = reg_wdata & MASK_WMASK;
    end
    if (reg_rd) begin
      rvalid_next = 1'b1;
      case (1'b1)
        hit(reg_addr, CONTROL_ADDR): rdata_next = control_reg;
        hit(reg_addr, MASK_ADDR):    rdata_next = mask_reg;
        hit(reg_addr, STATUS_ADDR):  rdata_next = status_reg;
        default:                     rdata_next = '0;
      endcase
      // Read clears all; an event in the same cycle still lands
      if (hit(reg_addr, STATUS_ADDR)) begin
        status_next = '0;
      end
    end
    status_next = (status_next | events) & MASK_WMASK;
    // Flags are gated per source by the matching mask bit
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clk) begin
    if (bank_reset) begin
      control_reg  <= CONTROL_RESET;
      mask_reg     <= MASK_RESET;
      status_reg   <= STATUS_RESET;
      level_reg    <= '0;
      chan_cnt_reg <= '0;
      flush_reg    <= '0;
      por_clr_reg  <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      control_reg  <= control_next;
      mask_reg     <= mask_next;
      status_reg   <= status_next;
      level_reg    <= level_next;
      chan_cnt_reg <= chan_cnt_next;
      flush_reg    <= flush_next;
      por_clr_reg  <= por_clr_next;
      irq_reg      <= irq_next;
    end
  end

  // Read data survives internal resets so the bus answer is not lost
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Supply state held in its own flop: hard reset forces it off for the pulse and one cycle after
  logic             supply_reg, supply_next;
  logic [5:0]       frame_reg, frame_next;
  logic [REG_W-1:0] control_eff;

  always_comb begin
    // Track what control_reg will hold, so internal resets and lost writes stay in step
    control_eff = bank_reset ? CONTROL_RESET : control_next;
    supply_next = !control_eff[SUPPLY_OFF_BIT] && !hard_pulse && !hard_req;
    frame_next  = control_eff[FRAME_CHECK_BIT] ? FRAME_LONG : FRAME_SHORT;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      supply_reg <= 1'b1;
      frame_reg  <= FRAME_SHORT;
    end else begin
      supply_reg <= supply_next;
      frame_reg  <= frame_next;
    end
  end

  assign reg_rdata               = rdata_reg;
  assign reg_rvalid              = rvalid_reg;
  assign frame_check_select      = control_reg[FRAME_CHECK_BIT];
  assign frame_bits              = frame_reg;
  assign shared_threshold_select = control_reg[SHARED_THR_BIT];
  assign average_flush           = flush_reg;
  assign field_supply_on         = supply_reg;
  assign power_on_flag_clear     = por_clr_reg;
  assign core_reset              = core_pulse;
  assign hard_reset_out          = hard_pulse;
  assign irq                     = irq_reg;
endmodule // adc_ctrl_bank

// ==== logic/adc_ctrl_pkg.sv ====
// Register offsets, field positions and reset values of the control bank
package adc_ctrl_pkg;
  localparam int          REG_W            = 16;
  localparam int          ADDR_W           = 6;
  localparam int          CHANNELS         = 4;
  // Register addresses on the serial register port
  localparam logic [5:0]  STATUS_ADDR      = 6'h12;
  localparam logic [5:0]  MASK_ADDR        = 6'h13;
  localparam logic [5:0]  CONTROL_ADDR     = 6'h14;
  // Control fields
  localparam int          FRAME_CHECK_BIT  = 15;
  localparam int          SHARED_THR_BIT   = 14;
  localparam int          FLUSH_LSB        = 4;
  localparam int          SUPPLY_OFF_BIT   = 3;
  localparam int          POR_CLEAR_BIT    = 2;
  localparam int          SOFT_RESET_BIT   = 1;
  localparam int          HARD_RESET_BIT   = 0;
  localparam logic [15:0] CONTROL_WMASK    = 16'hC0F8;
  localparam logic [15:0] CONTROL_RESET    = 16'h0000;
  // Interrupt mask and status fields
  localparam int          DONE_BIT         = 12;
  localparam int          FAULT_BIT        = 11;
  localparam int          LOSS_BIT         = 10;
  localparam int          FRAME_ERR_BIT    = 9;
  localparam int          CHECK_ERR_BIT    = 8;
  localparam int          RISE_LSB         = 4;
  localparam int          FALL_LSB         = 0;
  localparam logic [15:0] MASK_WMASK       = 16'h1FFF;
  localparam logic [15:0] MASK_RESET       = 16'h0000;
  localparam logic [15:0] STATUS_RESET     = 16'h0000;
  // Reset pulse widths in cycles
  localparam int          RESET_PULSE_CYC  = 4;
  // Frame lengths in serial bits
  localparam logic [5:0]  FRAME_SHORT      = 6'h18;
  localparam logic [5:0]  FRAME_LONG       = 6'h20;
endpackage

// ==== logic/pulse_stretch.sv ====
// Stretches a one-cycle request into a fixed-width reset pulse
`timescale 1ns/1ps
module pulse_stretch #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Request and pulse
  input  wire logic trigger,
  output logic      pulse
);
  localparam int CW = $clog2(WIDTH + 1);
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          pulse_reg;
  logic          pulse_next;

  initial begin
    if (WIDTH < 1) begin
      $error("pulse_stretch: WIDTH must be at least 1");
    end
  end

  always_comb begin
    count_next = count_reg;
    if (trigger) begin
      count_next = CW'(WIDTH);
    end else if (count_reg != '0) begin
      count_next = count_reg - CW'(1);
    end
    pulse_next = (count_next != '0);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse = pulse_reg;
endmodule // pulse_stretch
